// File: hdl/scpg_map.vh
`ifndef SCPG_MAP_VH
`define SCPG_MAP_VH

// Register indices on the plain register port
`define SCPG_ADDR_SYSCLK_CTRL   2'h0
`define SCPG_ADDR_MULT_CTRL     2'h1
`define SCPG_ADDR_STATUS        2'h2

// System clock control field positions
`define SCPG_BIT_PIN_DISABLE    7
`define SCPG_BIT_RESERVED6      6
`define SCPG_BIT_SWITCH_MODE    3
`define SCPG_DIV_MSB            2
`define SCPG_DIV_LSB            0

// Multiplier control field positions
`define SCPG_MULT_MSB           1
`define SCPG_MULT_LSB           0

// Reset values
`define SCPG_RST_SYSCLK_CTRL    8'h00
`define SCPG_RST_MULT_CTRL      8'h00
`define SCPG_RST_MULT           2'h0
`define SCPG_RST_DIV            3'h0

// Multiplier codes
`define SCPG_MULT_X1            2'h0
`define SCPG_MULT_X2            2'h1
`define SCPG_MULT_X4            2'h2
`define SCPG_MULT_BAD           2'h3

// Divide codes at or above this value are prohibited
`define SCPG_DIV_FIRST_BAD      3'h6

// Power mode codes on the mode pins
`define SCPG_MODE_NORMAL        3'h0
`define SCPG_MODE_SLEEP         3'h1
`define SCPG_MODE_ALL_STOP      3'h2
`define SCPG_MODE_SW_STANDBY    3'h3
`define SCPG_MODE_HW_STANDBY    3'h4

// Clock states
`define SCPG_ST_RUN             2'h0
`define SCPG_ST_STOP            2'h1
`define SCPG_ST_WAIT            2'h2

// Standby exit wait: cycles per step of the wait select code
`define SCPG_WAIT_UNIT_CYCLES   256

`endif

// File: hdl/scpg_divider.v
`timescale 1ns/1ps
module scpg_divider (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       run_in,
  input  wire       tick_in,
  input  wire [2:0] ratio_in,
  output reg        phi_out,
  output wire       period_end_out
);
  reg  [4:0] count;     // Multiplier ticks since last toggle
  reg  [4:0] term;      // Terminal count for the ratio in use
  wire       wrap;      // Last tick of a half period

  // Terminal count per divide code; prohibited codes never reach here
  always @* begin
    case (ratio_in)
      3'h0:    term = 5'h00;
      3'h1:    term = 5'h01;
      3'h2:    term = 5'h03;
      3'h3:    term = 5'h07;
      3'h4:    term = 5'h0f;
      3'h5:    term = 5'h1f;
      default: term = 5'h00;
    endcase
  end

  assign wrap = tick_in && (count == term);
  // A full period ends as phi goes back low; ratio swaps are safe here
  assign period_end_out = wrap && phi_out;

  // Counter and output toggle, parked low while stopped
  always @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      count   <= 5'h00;
      phi_out <= 1'b0;
    end else if (wrap) begin
      count   <= 5'h00;
      phi_out <= ~phi_out;
    end else if (tick_in) begin
      count   <= count + 5'h01;
    end
  end
endmodule

// File: hdl/scpg_top.v
// How it works
// - Oscillator, multiplier, divider in series
// - Normal and sleep: pin shows clock or high
// - All module stop: pin shows clock or high
// - Software standby high, hardware standby floats
// - Bit 6 stored, software writes zero
// - Bits 5 and 4 read zero
// - Deferred mode waits for software standby
// - Immediate mode applies multiplier at the next full period end
// - Divide by 2 to 64, 11X prohibited
// - Multiplier x1, x2, x4; code 11 prohibited
// - Load in standby, wait before resuming
// - Multiplier is one after reset
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "scpg_map.vh"
module scpg_top #(
  parameter WAIT_UNIT = `SCPG_WAIT_UNIT_CYCLES
) (
  input  wire       CLK_IN,
  input  wire       RST_IN,
  input  wire [1:0] ADDR_IN,
  input  wire [7:0] WDATA_IN,
  input  wire       WR_IN,
  input  wire       RD_IN,
  output reg  [7:0] RDATA_OUT,
  input  wire [2:0] MODE_IN,
  input  wire [3:0] WAIT_SEL_IN,
  output wire       SYSCLK_OUT,
  output reg        CLK_PIN_OUT,
  output reg        CLK_PIN_OE_OUT,
  output reg        CLK_STABLE_OUT
);
  // Clock states
  localparam [1:0] st_run  = 2'h0;     // Chain running
  localparam [1:0] st_stop = 2'h1;     // Chain stopped in standby
  localparam [1:0] st_wait = 2'h2;     // Settling wait after standby

  // Register contents
  reg        clock_pin_output_disable; // Pin gating bit
  reg        reserved6;                // Plain storage bit
  reg        multiplier_switch_mode;   // 1 means apply at the next full period end
  reg  [2:0] divide_select;            // Last valid divide code
  reg  [1:0] multiplier_select;        // Last valid multiplier code

  // Settings in effect
  reg  [1:0] active_mult;              // Multiplier the chain runs on
  reg  [2:0] active_div;               // Divide code the chain runs on

  // Mode pins synchroniser
  reg  [2:0] mode_meta;                // First stage, read by stage two only
  reg  [2:0] mode_sync;                // Safe copy of the mode pins

  // Clock state machine
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg [15:0] wait_count;               // Cycles left before restart
  reg [15:0] wait_total;               // Wait length for this exit

  // Chain internals
  reg  [1:0] osc_phase;                // Oscillator phase in fast cycles
  reg        mult_tick;                // One pulse per multiplied edge
  wire       run;
  wire       period_end;
  wire       in_standby;
  wire       div_ok;
  wire       mult_ok;

  assign run        = (state == st_run);
  assign in_standby = (mode_sync == `SCPG_MODE_SW_STANDBY) ||
                      (mode_sync == `SCPG_MODE_HW_STANDBY);
  assign div_ok     = (WDATA_IN[`SCPG_DIV_MSB:`SCPG_DIV_LSB] <
                       `SCPG_DIV_FIRST_BAD);
  assign mult_ok    = (WDATA_IN[`SCPG_MULT_MSB:`SCPG_MULT_LSB] !=
                       `SCPG_MULT_BAD);

  // Mode pins come from outside the clock domain
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_meta <= `SCPG_MODE_NORMAL;
      mode_sync <= `SCPG_MODE_NORMAL;
    end else begin
      mode_meta <= MODE_IN;
      mode_sync <= mode_meta;
    end
  end

  // Register writes
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      clock_pin_output_disable <= 1'b0;
      reserved6                <= 1'b0;
      multiplier_switch_mode   <= 1'b0;
      divide_select            <= `SCPG_RST_DIV;
      multiplier_select        <= `SCPG_RST_MULT;
    end else if (WR_IN) begin
      if (ADDR_IN == `SCPG_ADDR_SYSCLK_CTRL) begin
        clock_pin_output_disable <= WDATA_IN[`SCPG_BIT_PIN_DISABLE];
        reserved6 <= WDATA_IN[`SCPG_BIT_RESERVED6];
        multiplier_switch_mode <= WDATA_IN[`SCPG_BIT_SWITCH_MODE];
        // Prohibited codes are dropped, not stored
        if (div_ok) begin
          divide_select <= WDATA_IN[`SCPG_DIV_MSB:`SCPG_DIV_LSB];
        end
      end else if (ADDR_IN == `SCPG_ADDR_MULT_CTRL) begin
        // Code 11 would leave the multiplier undefined
        if (mult_ok) begin
          multiplier_select <=
            WDATA_IN[`SCPG_MULT_MSB:`SCPG_MULT_LSB];
        end
      end
    end
  end

  // Register reads, data valid in the next cycle
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `SCPG_ADDR_SYSCLK_CTRL: begin
          // Bits 5 and 4 are hard zero
          RDATA_OUT <= {clock_pin_output_disable, reserved6, 2'b00,
                        multiplier_switch_mode, divide_select};
        end
        `SCPG_ADDR_MULT_CTRL: begin
          RDATA_OUT <= {6'h00, multiplier_select};
        end
        `SCPG_ADDR_STATUS: begin
          RDATA_OUT <= {1'b0, state, active_mult, active_div};
        end
        default: begin
          RDATA_OUT <= 8'h00;
        end
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  // Oscillator phase; one oscillator period is four fast cycles
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      osc_phase <= 2'h0;
    end else begin
      osc_phase <= osc_phase + 2'h1;
    end
  end

  // Multiplier stage: pulse rate is oscillator rate times factor
  always @* begin
    case (active_mult)
      `SCPG_MULT_X1: mult_tick = (osc_phase == 2'h3);
      `SCPG_MULT_X2: mult_tick = osc_phase[0];
      `SCPG_MULT_X4: mult_tick = 1'b1;
      default:       mult_tick = (osc_phase == 2'h3);
    endcase
  end

  // Settings in effect
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      active_mult <= `SCPG_RST_MULT;
      active_div  <= `SCPG_RST_DIV;
    end else if (state == st_stop) begin
      // Chain is stopped, so any change is glitch free
      active_div <= divide_select;
      if (mode_sync == `SCPG_MODE_SW_STANDBY) begin
        active_mult <= multiplier_select;
      end
    end else if (run && period_end) begin
      // Swap only as a full period closes
      active_div <= divide_select;
      if (multiplier_switch_mode) begin
        active_mult <= multiplier_select;
      end
    end
  end

  // Wait length from the standby wait select code
  always @* begin
    wait_total = WAIT_UNIT[15:0] * {12'h000, WAIT_SEL_IN} +
                 WAIT_UNIT[15:0];
  end

  // Next clock state
  always @* begin
    next_state = state;
    case (state)
      st_run: begin
        if (in_standby) begin
          next_state = st_stop;
        end
      end
      st_stop: begin
        if (!in_standby) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (in_standby) begin
          next_state = st_stop;
        end else if (wait_count == 16'h0001) begin
          next_state = st_run;
        end
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  // State and wait counter
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      state      <= st_run;
      wait_count <= 16'h0000;
    end else begin
      state <= next_state;
      if (state == st_stop) begin
        wait_count <= wait_total;
      end else if (wait_count != 16'h0000) begin
        wait_count <= wait_count - 16'h0001;
      end
    end
  end

  // Divider stage produces the system clock
  scpg_divider u_div (
    .clk_in         (CLK_IN),
    .rst_in         (RST_IN),
    .run_in         (run),
    .tick_in        (mult_tick),
    .ratio_in       (active_div),
    .phi_out        (SYSCLK_OUT),
    .period_end_out (period_end)
  );

  // Clock pin drive per power mode
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      CLK_PIN_OUT    <= 1'b1;
      CLK_PIN_OE_OUT <= 1'b1;
      CLK_STABLE_OUT <= 1'b0;
    end else begin
      CLK_STABLE_OUT <= run;
      if (mode_sync == `SCPG_MODE_HW_STANDBY) begin
        // Pin floats; the disable bit does not matter
        CLK_PIN_OE_OUT <= 1'b0;
        CLK_PIN_OUT    <= 1'b1;
      end else if (!run) begin
        CLK_PIN_OE_OUT <= 1'b1;
        CLK_PIN_OUT    <= 1'b1;
      end else begin
        // Normal, sleep and all module stop behave alike here
        CLK_PIN_OE_OUT <= 1'b1;
        CLK_PIN_OUT    <= clock_pin_output_disable ? 1'b1 :
                          next_phi(SYSCLK_OUT);
      end
    end
  end

  // Pin follows the clock with one flop of delay
  function next_phi;
    input phi;
    begin
      next_phi = phi;
    end
  endfunction
endmodule

// File: bench/scpg_checker_sva.sv
`timescale 1ns/1ps
module scpg_checker #(
  parameter WAIT_UNIT = 2
) (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [2:0] MODE_IN,
  input wire logic [3:0] WAIT_SEL_IN,
  input wire logic       SYSCLK_OUT,
  input wire logic       CLK_PIN_OUT,
  input wire logic       CLK_PIN_OE_OUT,
  input wire logic       CLK_STABLE_OUT
);
  logic [7:0] sh;   // Expected control register
  logic       mt;   // Multiplier written since reset
  logic       seen; // Chain has run since reset
  int         lc;   // Cycles with the chain stopped
  int         lo_run;  // Low samples in the current low phase
  int         lo_n;    // Length of the last complete low phase
  int         hi_n;    // High samples in the current high phase
  logic       lo_calm; // Current low phase saw no chain stop
  logic       lo_ok;   // Last low phase saw no chain stop
  // Phase lengths of the system clock; a runt high shows as short
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      lo_run <= 0;
      lo_n <= 0;
      hi_n <= 0;
      lo_calm <= 1'b1;
      lo_ok <= 1'b0;
    end else if (SYSCLK_OUT) begin
      hi_n <= hi_n + 1;
      lo_run <= 0;
      lo_calm <= 1'b1;
      if (lo_run != 0) begin
        lo_n <= lo_run;
        lo_ok <= lo_calm && CLK_STABLE_OUT;
      end
    end else begin
      lo_run <= lo_run + 1;
      hi_n <= 0;
      lo_calm <= lo_calm && CLK_STABLE_OUT;
    end
  end
  // Shadow of control writes; prohibited divide codes are dropped
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      sh <= 8'h00;
      mt <= 1'b0;
      seen <= 1'b0;
      lc <= 0;
    end else begin
      if (WR_IN && ADDR_IN == 2'h0) begin
        sh[7:6] <= WDATA_IN[7:6];
        sh[3] <= WDATA_IN[3];
        if (WDATA_IN[2:0] < 3'h6) begin
          sh[2:0] <= WDATA_IN[2:0];
        end
      end
      if (WR_IN && ADDR_IN == 2'h1) begin
        mt <= 1'b1;
      end
      if (CLK_STABLE_OUT) begin
        seen <= 1'b1;
      end
      lc <= CLK_STABLE_OUT ? 0 : lc + 1;
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // Pin is registered, so the disable bit must hold two samples
  sequence s_hw;
    (MODE_IN == 3'h4)[*4];
  endsequence
  sequence s_run;
    (!sh[7] && CLK_STABLE_OUT)[*3];
  endsequence
  a_ctrl_readback: assert property (RD_IN && ADDR_IN == 2'h0
    |=> RDATA_OUT == $past(sh)) else $error("control readback wrong");
  a_bits54_zero: assert property (RD_IN && ADDR_IN == 2'h0
    |=> RDATA_OUT[5:4] == 2'h0) else $error("bits 5 4 not zero");
  a_mult_reset: assert property (RD_IN && ADDR_IN == 2'h1 && !mt
    |=> RDATA_OUT == 8'h00) else $error("multiplier not one");
  a_pin_disabled: assert property (sh[7][*2]
    |-> CLK_PIN_OUT) else $error("pin not held high");
  a_pin_follows: assert property (s_run
    |-> CLK_PIN_OUT == (CLK_PIN_OE_OUT ? $past(SYSCLK_OUT) : 1'b1))
    else $error("pin not clock");
  a_no_runt: assert property ($fell(SYSCLK_OUT) && lo_ok
    && CLK_STABLE_OUT |-> hi_n >= lo_n)
    else $error("short clock high phase");
  a_stop_pin_high: assert property (!CLK_STABLE_OUT
    |-> CLK_PIN_OUT) else $error("stopped pin not high");
  a_hw_float: assert property (s_hw
    |=> !CLK_PIN_OE_OUT) else $error("pin driven in hw standby");
  a_stopped_low: assert property ((!CLK_STABLE_OUT)[*3]
    |-> !SYSCLK_OUT) else $error("clock runs while stopped");
  a_wait_time: assert property ($rose(CLK_STABLE_OUT) && seen
    |-> lc >= (int'(WAIT_SEL_IN) + 1) * WAIT_UNIT)
    else $error("standby wait too short");
endmodule

// File: bench/test_system_clock_pulse_generator.sv
`timescale 1ns/1ps
module test_system_clock_pulse_generator;
  logic       clk;
  logic       rst;
  logic [1:0] addr;
  logic [7:0] wdat;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdat;
  logic [2:0] mode;
  logic [3:0] wsel;
  logic       sclk;
  logic       pin;
  logic       oe;
  int         n_fail;
  int         cmp_count;
  // Short wait unit keeps standby exits brief
  scpg_top #(.WAIT_UNIT(2)) i_dut (.CLK_IN(clk), .RST_IN(rst),
    .ADDR_IN(addr), .WDATA_IN(wdat), .WR_IN(wr_s), .RD_IN(rd_s),
    .RDATA_OUT(rdat), .MODE_IN(mode), .WAIT_SEL_IN(wsel),
    .SYSCLK_OUT(sclk), .CLK_PIN_OUT(pin), .CLK_PIN_OE_OUT(oe),
    .CLK_STABLE_OUT());
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({24'h0, rdat}, {24'h0, e});
  endtask
  // Settle past the longest period, then time one clock period
  task per(input int e);
    realtime t0;
    repeat (300) @(posedge clk);
    @(posedge sclk);
    t0 = $realtime;
    @(posedge sclk);
    chk(int'(($realtime - t0) / 40.0), e);
  endtask
  task lows(output int n);
    n = 0;
    repeat (8) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      n += (pin === 1'b0);
    end
  endtask
  task t_reset;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
  endtask
  task t_ctrl;
    wr(2'h0, 8'hff);
    rd(2'h0, 8'hc8);
    wr(2'h0, 8'h35);
    rd(2'h0, 8'h05);
    wr(2'h0, 8'h06);
    rd(2'h0, 8'h05);
  endtask
  task t_div;
    for (int d = 0; d < 6; d++) begin
      wr(2'h0, 8'(d));
      per(8 << d);
      rd(2'h2, 8'(d));
    end
  endtask
  task t_imm;
    for (int m = 0; m < 3; m++) begin
      wr(2'h0, 8'h08);
      wr(2'h1, 8'(m));
      per(8 >> m);
      rd(2'h2, 8'(m << 3));
    end
    wr(2'h1, 8'h03);
    rd(2'h1, 8'h02);
  endtask
  // Deferred mode: new factor only after a software standby
  task t_defer;
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h01);
    per(2);
    rd(2'h2, 8'h10);
    @(posedge clk);
    mode <= 3'h3;
    repeat (10) @(posedge clk);
    #1;
    chk(pin, 1);
    chk(oe, 1);
    rd(2'h2, 8'h28);
    @(posedge clk);
    mode <= 3'h0;
    per(4);
  endtask
  task t_hw;
    mode <= 3'h4;
    wr(2'h1, 8'h02);
    repeat (10) @(posedge clk);
    #1;
    chk(oe, 0);
    @(posedge clk);
    mode <= 3'h0;
    per(4);
  endtask
  task t_pins;
    int n;
    for (int m = 0; m < 3; m++) begin
      mode <= 3'(m);
      wr(2'h0, 8'h80);
      lows(n);
      chk(n, 0);
      wr(2'h0, 8'h00);
      lows(n);
      chk(n > 0, 1);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rst = 1'b1;
    addr = 2'h0;
    wdat = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    mode = 3'h0;
    wsel = 4'h1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ctrl;
    t_div;
    t_imm;
    t_defer;
    t_hw;
    t_pins;
    complete_run;
  end
  // Whole sequence needs about 5000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule
bind scpg_top scpg_checker #(.WAIT_UNIT(WAIT_UNIT)) u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .MODE_IN(MODE_IN), .WAIT_SEL_IN(WAIT_SEL_IN),
  .SYSCLK_OUT(SYSCLK_OUT), .CLK_PIN_OUT(CLK_PIN_OUT),
  .CLK_PIN_OE_OUT(CLK_PIN_OE_OUT), .CLK_STABLE_OUT(CLK_STABLE_OUT));
